//--- src/ebst_seq.sv
// Expansion bus access sequencer: address, setup, strobe, hold, recovery
`timescale 1ns/100ps
//Operation
// - Multiplexed mode: address latch strobe high 1 to 4 bus cycles, address valid.
// - Address latch strobe width set by address phase length.
// - Address held exactly one bus cycle after latch strobe falls.
// - Address phase length sets how long the address is presented.
// - Multiplexed mode: chip select asserts exactly one bus cycle after strobe falls.
// - Simplex mode: address valid 1 to 4 cycles before chip select.
// - Write data valid 1 to 4 cycles before write strobe falls.
// - Data setup phase length sets data lead before the strobe.
// - Write strobe stays asserted 1 to 16 bus cycles.
// - Strobe phase length sets strobe width; data stays available throughout.
// - Write data stays valid 1 to 4 cycles after write strobe rises.
// - Hold phase length sets hold of chip select, address and data.
// - Recovery gap of 1 to 16 cycles between accesses.
// - Recovery phase length sets the idle gap between accesses.
// - All phase lengths count expansion bus clock periods.
// - Simplex mode never drives the address latch strobe.
module ebst_seq
  import ebst_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic [EBST_DIV_W-1:0]   div_ratio,
  input  wire logic                    mux_mode,
  input  wire logic [EBST_SHORT_W-1:0] address_phase_len,
  input  wire logic [EBST_SHORT_W-1:0] data_setup_phase_len,
  input  wire logic [EBST_LONG_W-1:0]  strobe_phase_len,
  input  wire logic [EBST_SHORT_W-1:0] hold_phase_len,
  input  wire logic [EBST_LONG_W-1:0]  recovery_phase_len,
  input  wire logic                    req_valid,
  input  wire logic                    req_write,
  input  wire logic [EBST_ADDR_W-1:0]  req_addr,
  input  wire logic [EBST_DATA_W-1:0]  req_wdata,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [EBST_DATA_W-1:0]       rsp_rdata,
  output logic                         busy,
  output logic                         bus_clk_en,
  output logic                         address_latch_strobe,
  output logic                         chip_select_n,
  output logic                         write_strobe_n,
  output logic                         read_strobe_n,
  output logic [EBST_ADDR_W-1:0]       bus_addr_o,
  output logic [EBST_DATA_W-1:0]       bus_data_o,
  output logic                         bus_data_oe,
  input  wire logic [EBST_DATA_W-1:0]  bus_data_i
);
  ebst_state_e            state_reg;
  ebst_state_e            state_next;
  logic                   write_reg;
  logic                   write_next;
  logic                   mux_reg;
  logic                   mux_next;
  logic [EBST_ADDR_W-1:0] addr_reg;
  logic [EBST_ADDR_W-1:0] addr_next;
  logic [EBST_DATA_W-1:0] wdata_reg;
  logic [EBST_DATA_W-1:0] wdata_next;
  logic [EBST_DATA_W-1:0] rdata_reg;
  logic [EBST_DATA_W-1:0] rdata_next;
  logic                   rsp_reg;
  logic                   rsp_next;
  logic                   ale_reg;
  logic                   ale_next;
  logic                   cs_n_reg;
  logic                   cs_n_next;
  logic                   wr_n_reg;
  logic                   wr_n_next;
  logic                   rd_n_reg;
  logic                   rd_n_next;
  logic                   oe_reg;
  logic                   oe_next;
  logic                   bus_tick;
  logic                   load;
  logic [EBST_CNT_W-1:0]  load_val;
  logic                   last;

  // Programmed field encodes length minus one, so zero still gives one cycle
  function automatic logic [EBST_CNT_W-1:0] phase_load(input logic [EBST_LONG_W-1:0] f);
    phase_load = f;
  endfunction

  ebst_clk_div u_div (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .div_ratio (div_ratio),
    .bus_tick  (bus_tick)
  );

  ebst_phase_cnt u_cnt (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .bus_tick (bus_tick),
    .load     (load),
    .load_val (load_val),
    .last     (last)
  );

  // Requests are only taken on a bus tick so every phase spans whole bus cycles
  assign req_ready = (state_reg == EBST_IDLE) && bus_tick;

  always_comb
  begin
    state_next = state_reg;
    write_next = write_reg;
    mux_next   = mux_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rsp_next   = 1'b0;
    ale_next   = ale_reg;
    cs_n_next  = cs_n_reg;
    wr_n_next  = wr_n_reg;
    rd_n_next  = rd_n_reg;
    oe_next    = oe_reg;
    load       = 1'b0;
    load_val   = '0;
    case (state_reg)
      EBST_IDLE:
      begin
        if (req_valid && bus_tick)
        begin
          write_next = req_write;
          mux_next   = mux_mode;
          addr_next  = req_addr;
          wdata_next = req_wdata;
          ale_next   = mux_mode;
          load       = 1'b1;
          load_val   = phase_load({2'b00, address_phase_len});
          state_next = EBST_ADDR;
        end
      end
      EBST_ADDR:
      begin
        if (last)
        begin
          ale_next = 1'b0;
          load     = 1'b1;
          if (mux_reg)
          begin
            load_val   = EBST_ADDR_HOLD - 1'b1;
            state_next = EBST_AHOLD;
          end
          else
          begin
            cs_n_next  = 1'b0;
            oe_next    = write_reg;
            load_val   = phase_load({2'b00, data_setup_phase_len});
            state_next = EBST_SETUP;
          end
        end
      end
      EBST_AHOLD:
      begin
        // Address hold is fixed; chip select follows the latch strobe by one cycle
        if (last)
        begin
          cs_n_next  = 1'b0;
          oe_next    = write_reg;
          load       = 1'b1;
          load_val   = phase_load({2'b00, data_setup_phase_len});
          state_next = EBST_SETUP;
        end
      end
      EBST_SETUP:
      begin
        if (last)
        begin
          wr_n_next  = ~write_reg;
          rd_n_next  = write_reg;
          load       = 1'b1;
          load_val   = phase_load(strobe_phase_len);
          state_next = EBST_STROBE;
        end
      end
      EBST_STROBE:
      begin
        if (last)
        begin
          if (!write_reg)
          begin
            rdata_next = bus_data_i;
            rsp_next   = 1'b1;
          end
          else
            rsp_next = 1'b1;
          wr_n_next  = 1'b1;
          rd_n_next  = 1'b1;
          load       = 1'b1;
          load_val   = phase_load({2'b00, hold_phase_len});
          state_next = EBST_HOLD;
        end
      end
      EBST_HOLD:
      begin
        if (last)
        begin
          cs_n_next  = 1'b1;
          oe_next    = 1'b0;
          load       = 1'b1;
          load_val   = phase_load(recovery_phase_len);
          state_next = EBST_RECOV;
        end
      end
      EBST_RECOV:
      begin
        if (last)
          state_next = EBST_IDLE;
      end
      default:
      begin
        state_next = EBST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= EBST_IDLE;
      write_reg <= 1'b0;
      mux_reg   <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
      ale_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      oe_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      write_reg <= write_next;
      mux_reg   <= mux_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
      ale_reg   <= ale_next;
      cs_n_reg  <= cs_n_next;
      wr_n_reg  <= wr_n_next;
      rd_n_reg  <= rd_n_next;
      oe_reg    <= oe_next;
    end
  end

  // Address and data stay put from address phase through hold; no mid-access change
  assign bus_addr_o           = addr_reg;
  assign bus_data_o           = wdata_reg;
  assign bus_data_oe          = oe_reg;
  assign address_latch_strobe = ale_reg;
  assign chip_select_n        = cs_n_reg;
  assign write_strobe_n       = wr_n_reg;
  assign read_strobe_n        = rd_n_reg;
  assign rsp_valid            = rsp_reg;
  assign rsp_rdata            = rdata_reg;
  assign busy                 = (state_reg != EBST_IDLE);
  assign bus_clk_en           = bus_tick;
endmodule

//--- src/ebst_pkg.sv
// Package of constants and types for the expansion bus strobe timing sequencer
package ebst_pkg;
  localparam int unsigned EBST_ADDR_W     = 24;
  localparam int unsigned EBST_DATA_W     = 16;
  localparam int unsigned EBST_SHORT_W    = 2;
  localparam int unsigned EBST_LONG_W     = 4;
  localparam int unsigned EBST_CNT_W      = 4;
  localparam int unsigned EBST_DIV_W      = 8;
  localparam logic [7:0]  EBST_DIV_RESET  = 8'h03;
  localparam logic [3:0]  EBST_ADDR_HOLD  = 4'h1;
  typedef enum logic [2:0] {
    EBST_IDLE,
    EBST_ADDR,
    EBST_AHOLD,
    EBST_SETUP,
    EBST_STROBE,
    EBST_HOLD,
    EBST_RECOV
  } ebst_state_e;
endpackage

//--- src/ebst_clk_div.sv
// Expansion bus clock divider giving a one-cycle tick enable
`timescale 1ns/100ps
module ebst_clk_div
  import ebst_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [EBST_DIV_W-1:0] div_ratio,
  output logic                       bus_tick
);
  logic [EBST_DIV_W-1:0] cnt_reg;
  logic [EBST_DIV_W-1:0] cnt_next;
  logic                  tick_reg;
  logic                  tick_next;

  always_comb
  begin
    if (cnt_reg >= div_ratio)
    begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
    else
    begin
      cnt_next  = cnt_reg + 1'b1;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign bus_tick = tick_reg;
endmodule

//--- src/ebst_phase_cnt.sv
// Down counter for one phase length, stepped on bus ticks
`timescale 1ns/100ps
module ebst_phase_cnt
  import ebst_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  bus_tick,
  input  wire logic                  load,
  input  wire logic [EBST_CNT_W-1:0] load_val,
  output logic                       last
);
  logic [EBST_CNT_W-1:0] cnt_reg;
  logic [EBST_CNT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
      cnt_next = load_val;
    else if (bus_tick && cnt_reg != '0)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  // Phase ends on the tick that finishes the last programmed cycle
  assign last = bus_tick && (cnt_reg == '0);
endmodule

//--- verif/ebst_seq_asserts.sv
// Port checker for the expansion bus sequencer, bound to its top module
`timescale 1ns/100ps
module ebst_seq_chk
  import ebst_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   sys_rst,
  input wire logic                   mux_mode,
  input wire logic                   req_ready,
  input wire logic                   rsp_valid,
  input wire logic [EBST_DATA_W-1:0] rsp_rdata,
  input wire logic                   busy,
  input wire logic                   address_latch_strobe,
  input wire logic                   chip_select_n,
  input wire logic                   write_strobe_n,
  input wire logic                   read_strobe_n,
  input wire logic [EBST_ADDR_W-1:0] bus_addr_o,
  input wire logic [EBST_DATA_W-1:0] bus_data_o,
  input wire logic                   bus_data_oe,
  input wire logic [EBST_DATA_W-1:0] bus_data_i
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Bound of 64 covers four ticks at the slow divider settings the bench uses
  sequence s_cs_after_ale;
    chip_select_n ##[1:64] !chip_select_n;
  endsequence
  property p_ale_addr;
    address_latch_strobe && $past(address_latch_strobe) |-> $stable(bus_addr_o) && chip_select_n;
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("ale addr");
  property p_cs_after_ale;
    $fell(address_latch_strobe) |-> s_cs_after_ale;
  endproperty
  a_cs_after_ale: assert property (p_cs_after_ale) else $error("cs late");
  property p_ale_mode;
    address_latch_strobe |-> mux_mode;
  endproperty
  a_ale_mode: assert property (p_ale_mode) else $error("ale simplex");
  property p_wr_strobe;
    !write_strobe_n |-> !chip_select_n && bus_data_oe && read_strobe_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("wr strobe");
  property p_data_setup;
    $fell(write_strobe_n) |-> $past(bus_data_oe) && !$past(chip_select_n) && $stable(bus_data_o);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("setup");
  property p_data_hold;
    $rose(write_strobe_n) |-> bus_data_oe && !chip_select_n && $stable(bus_data_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("hold");
  property p_cs_release;
    $rose(chip_select_n) |-> write_strobe_n && read_strobe_n && busy && !req_ready;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("release");
  property p_rd_capture;
    $rose(read_strobe_n) |-> rsp_valid && rsp_rdata == $past(bus_data_i);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("capture");
endmodule
bind ebst_seq ebst_seq_chk u_chk (.*);

//--- verif/ebst_periph.sv
// Peripheral model: a small memory behind the chip select and strobes
`timescale 1ns/100ps
module ebst_periph
  import ebst_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   chip_select_n,
  input  wire logic                   write_strobe_n,
  input  wire logic                   read_strobe_n,
  input  wire logic [EBST_ADDR_W-1:0] bus_addr_o,
  input  wire logic [EBST_DATA_W-1:0] bus_data_o,
  output logic      [EBST_DATA_W-1:0] bus_data_i
);
  logic [EBST_DATA_W-1:0] mem [16];
  logic [EBST_DATA_W-1:0] last = 16'h0000;
  // Off the strobe the line toggles, so a capture at the wrong edge cannot pass
  assign bus_data_i = (!read_strobe_n && !chip_select_n) ? mem[bus_addr_o[3:0]] : ~last;
  always @(posedge clk_sys)
  begin
    last <= bus_data_i;
    if (!write_strobe_n && !chip_select_n)
      mem[bus_addr_o[3:0]] <= bus_data_o;
  end
endmodule

//--- verif/test_ebst_seq.sv
// Self-checking bench for the expansion bus sequencer
`timescale 1ns/100ps
module test_ebst_seq
  import ebst_pkg::*;
;
  logic                    clk_sys = 1'b0, sys_rst = 1'b1, mux_mode = 1'b0;
  logic                    req_valid = 1'b0, req_write = 1'b0;
  logic [EBST_DIV_W-1:0]   div_ratio = 8'h00;
  logic [EBST_SHORT_W-1:0] address_phase_len = 2'h0, data_setup_phase_len = 2'h0;
  logic [EBST_SHORT_W-1:0] hold_phase_len = 2'h0;
  logic [EBST_LONG_W-1:0]  strobe_phase_len = 4'h0, recovery_phase_len = 4'h0;
  logic [EBST_ADDR_W-1:0]  req_addr = 24'h000000, bus_addr_o;
  logic [EBST_DATA_W-1:0]  req_wdata = 16'h0000, rsp_rdata, bus_data_o, bus_data_i;
  logic                    req_ready, rsp_valid, busy, bus_clk_en, address_latch_strobe;
  logic                    chip_select_n, write_strobe_n, read_strobe_n, bus_data_oe;
  logic [2:0]              sig, sig_q = 3'h2;
  logic                    done = 1'b0;
  int                      run = 0, cyc = 0, errors = 0, check_count = 0;
  int                      wid [16];
  ebst_seq u_dut (.*);
  ebst_periph u_periph (.*);
  initial forever #2 clk_sys = ~clk_sys;
  // Run lengths of each bus phase, keyed by strobe-seen flag and pin levels
  assign sig = {address_latch_strobe, chip_select_n, ~(write_strobe_n & read_strobe_n)};
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      conclude();
    end
    if (sig != sig_q)
    begin
      wid[{done, sig_q}] = run;
      run = 0;
    end
    run++;
    if (sig[0])
      done = 1'b1;
    if (sig[1])
      done = 1'b0;
    sig_q = sig;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] dat, input int k);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= {20'h00000, k[3:0]};
    req_wdata <= dat;
    @(posedge clk_sys);
    while (req_ready !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(bus_addr_o, {20'h00000, k[3:0]});
    if (!wr)
      chk(rsp_rdata, dat);
    while (busy !== 1'b0 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    // A hung access counts as a mismatch
    if (n >= 400)
      errors++;
  endtask
  // Each case writes then reads back one word; widths are in clk_sys cycles
  task automatic run_case(input logic m, input int a, s, w, h, r, d, k);
    int t;
    t = d + 1;
    @(posedge clk_sys);
    mux_mode <= m;
    address_phase_len <= a[1:0];
    data_setup_phase_len <= s[1:0];
    strobe_phase_len <= w[3:0];
    hold_phase_len <= h[1:0];
    recovery_phase_len <= r[3:0];
    div_ratio <= d[7:0];
    for (int i = 0; i < 2; i++)
    begin
      acc(i == 0, 16'ha5c3 ^ k[15:0], k);
      if (m)
      begin
        chk(wid[6], (a + 1) * t);
        chk(wid[2], t);
      end
      else if (i == 1)
        chk(wid[2] >= (a + r + 2) * t, 32'h1);
      chk(wid[0], (s + 1) * t);
      chk(wid[9], (w + 1) * t);
      chk(wid[8], (h + 1) * t);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk({address_latch_strobe, chip_select_n, write_strobe_n, read_strobe_n, busy}, 32'he);
    run_case(1'b1, 0, 0, 0, 0, 0, 0, 1);
    run_case(1'b1, 3, 3, 15, 3, 15, 0, 2);
    run_case(1'b0, 2, 1, 5, 2, 3, 1, 3);
    run_case(1'b0, 1, 2, 1, 1, 0, 0, 4);
    run_case(1'b1, 1, 0, 2, 0, 1, 2, 5);
    conclude();
  end
endmodule
